// ===== src/sram_if_pkg.sv
// Purpose: Shared constants for the burst-of-two DDR SRAM bus interface
// Assumes: Pin-side timing is oversampled by the core clock
// Notes:   Latencies are counted in half periods of the true input clock
package sram_if_pkg;
   // Supported data bus widths
   localparam int WIDTH_X8  = 8;
   localparam int WIDTH_X9  = 9;
   localparam int WIDTH_X18 = 18;
   localparam int WIDTH_X36 = 36;
   // Write-select lines per width
   localparam int SELS_X8   = 2;
   localparam int SELS_X9   = 1;
   localparam int SELS_X18  = 2;
   localparam int SELS_X36  = 4;
   // Words moved per loaded address
   localparam int BURST_LEN = 2;
   // Read launch delay in half periods, DLL running and DLL off
   localparam int LAT_DLL_ON  = 4;
   localparam int LAT_DLL_OFF = 3;
   // Depth of the half-period read pipeline
   localparam int PIPE_DEPTH  = LAT_DLL_ON + BURST_LEN;
   // Synchroniser length for pin inputs
   localparam int SYNC_STAGES = 2;
   // Write beat buffer depth
   localparam int FIFO_DEPTH  = 4;
   // Bank of each beat
   localparam logic BANK_FIRST  = 1'h0;
   localparam logic BANK_SECOND = 1'h1;

   function automatic int sel_count(input int width);
      case (width)
         WIDTH_X8:  sel_count = SELS_X8;
         WIDTH_X9:  sel_count = SELS_X9;
         WIDTH_X18: sel_count = SELS_X18;
         default:   sel_count = SELS_X36;
      endcase
   endfunction
endpackage

// ===== src/beat_fifo.sv
// Purpose: Small valid/ready FIFO for captured write beats
// Assumes: Single clock, synchronous active-high reset
// Notes:   Full and empty are exact; no bypass path
`timescale 1ns/1ps
module beat_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             inValid,
   output      logic             inReady,
   input  wire logic [WIDTH-1:0] inData,
   output      logic             outValid,
   input  wire logic             outReady,
   output      logic [WIDTH-1:0] outData
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wrPtr_r;
   logic [PW-1:0]    rdPtr_r;
   logic [PW:0]      count_r;
   logic             push;
   logic             pop;

   assign inReady  = (count_r != (PW+1)'(DEPTH));
   assign outValid = (count_r != '0);
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;
   assign outData  = mem[rdPtr_r];

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH-1)) ? '0 : p + PW'(1);
   endfunction

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wrPtr_r] <= inData;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wrPtr_r <= bump(wrPtr_r);
         end
         if (pop) begin
            rdPtr_r <= bump(rdPtr_r);
         end
         count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   a_fifo_bounded: assert property (@(posedge mclk) disable iff (rst)
      count_r <= (PW+1)'(DEPTH)) else $error("fifo count above depth");
   a_fifo_stall_holds: assert property (@(posedge mclk) disable iff (rst)
      outValid && !outReady |=> outValid && $stable(outData))
      else $error("fifo head lost while stalled");
endmodule

// ===== src/sram_burst_store.sv
// Purpose: Two half-depth arrays holding the first and second word of each burst
// Assumes: One access per clock; a fetch reads both arrays at once
// Notes:   Lane width is the data width divided by the number of select lines
`timescale 1ns/1ps
module sram_burst_store #(
   parameter int DATA_W = 36,
   parameter int SEL_W  = 4,
   parameter int ADDR_W = 10
) (
   input  wire logic              mclk,
   input  wire logic              writeEn,
   input  wire logic              writeBank,
   input  wire logic [ADDR_W-1:0] writeAddr,
   input  wire logic [DATA_W-1:0] writeData,
   input  wire logic [SEL_W-1:0]  laneEn,
   input  wire logic              fetchEn,
   input  wire logic [ADDR_W-1:0] fetchAddr,
   output      logic [DATA_W-1:0] firstWord_r,
   output      logic [DATA_W-1:0] secondWord_r
);
   import sram_if_pkg::*;

   localparam int LANE_W = DATA_W / SEL_W;
   localparam int DEPTH  = 1 << ADDR_W;

   logic [DATA_W-1:0] bankFirst  [DEPTH];
   logic [DATA_W-1:0] bankSecond [DEPTH];

   // Unselected lanes keep their stored value
   for (genvar i = 0; i < SEL_W; i++) begin : g_lane
      always_ff @(posedge mclk) begin
         if (writeEn && laneEn[i] && writeBank == BANK_FIRST) begin
            bankFirst[writeAddr][i*LANE_W +: LANE_W] <= writeData[i*LANE_W +: LANE_W];
         end
         if (writeEn && laneEn[i] && writeBank == BANK_SECOND) begin
            bankSecond[writeAddr][i*LANE_W +: LANE_W] <= writeData[i*LANE_W +: LANE_W];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (fetchEn) begin
         firstWord_r  <= bankFirst[fetchAddr];
         secondWord_r <= bankSecond[fetchAddr];
      end
   end
endmodule

// ===== src/ddr_burst2_sram_bus_interface.sv
// Purpose: Memory-side bus interface of a burst-of-two DDR pipelined SRAM
// Assumes: Input clocks are slow enough for mclk to oversample them
// Notes:   All pins pass a two-stage synchroniser before any logic
// Functional notes
// - Write data sampled on both clock edges
// - Read words launched on both rising edges
// - Data pins released when no read drives
// - Bus width 8, 9, 18 or 36 bits
// - Every access moves exactly two words
// - Two nibble selects gate the 8-bit write
// - Deselected nibble leaves stored nibble unchanged
// - Byte selects sampled on both edges
// - Deselected byte leaves stored byte unchanged
// - Shared address sampled at true edge on load
// - Direction high reads, low writes
// - Two half-depth arrays supply both words
// - Valid flag marks read data, echo aligned
// - Free-running complementary echo clocks
// - Accesses start only on true edge
// - DLL disabled selects older shorter timing
`timescale 1ns/1ps
module ddr_burst2_sram_bus_interface
   import sram_if_pkg::*;
#(
   parameter int DATA_W = sram_if_pkg::WIDTH_X36,
   parameter int ADDR_W = 10
) (
   input  wire logic                                       mclk,
   input  wire logic                                       rst,
   input  wire logic                                       kClk,
   input  wire logic                                       kClkN,
   input  wire logic                                       load_strobe_n,
   input  wire logic                                       readNotWrite,
   input  wire logic [ADDR_W-1:0]                          addr,
   input  wire logic [sram_if_pkg::sel_count(DATA_W)-1:0]  writeSelN,
   input  wire logic                                       dll_disable_n,
   input  wire logic [DATA_W-1:0]                          dqIn,
   output      logic [DATA_W-1:0]                          dqOut_r,
   output      logic                                       dqOe_r,
   output      logic                                       output_valid_flag_r,
   output      logic                                       echo_timing_out_r,
   output      logic                                       echoTimingOutN_r
);
   import sram_if_pkg::*;

   localparam int SEL_W  = sel_count(DATA_W);
   localparam int SYNC_W = 5 + ADDR_W + SEL_W + DATA_W;
   localparam int WORD_W = 1 + ADDR_W + SEL_W + DATA_W;

   typedef enum logic [1:0] {
      WR_IDLE   = 2'h0,
      WR_FIRST  = 2'h1,
      WR_SECOND = 2'h2
   } wr_state_type;

   // Synchroniser: stage 0 is read by stage 1 only
   // Clocks, strobes and data share one synchroniser so they stay aligned
   logic [SYNC_W-1:0] sync0_r;
   logic [SYNC_W-1:0] sync1_r;
   logic              kPrev_r;
   logic              kNPrev_r;

   always_ff @(posedge mclk) begin
      if (rst) begin
         sync0_r <= '0;
         sync1_r <= '0;
      end else begin
         sync0_r <= {kClk, kClkN, load_strobe_n, readNotWrite, dll_disable_n,
                     addr, writeSelN, dqIn};
         sync1_r <= sync0_r;
      end
   end

   logic              kS;
   logic              kNS;
   logic              loadNS;
   logic              rdS;
   logic              dllOnS;
   logic [ADDR_W-1:0] addrS;
   logic [SEL_W-1:0]  selNS;
   logic [DATA_W-1:0] dataS;
   logic              kRise;
   logic              kNRise;
   logic              halfEdge;

   assign {kS, kNS, loadNS, rdS, dllOnS, addrS, selNS, dataS} = sync1_r;

   always_ff @(posedge mclk) begin
      if (rst) begin
         kPrev_r  <= 1'h0;
         kNPrev_r <= 1'h0;
      end else begin
         kPrev_r  <= kS;
         kNPrev_r <= kNS;
      end
   end

   assign kRise    = kS && !kPrev_r;
   assign kNRise   = kNS && !kNPrev_r;
   assign halfEdge = kRise || kNRise;

   // load taken only at true edge
   logic loadRead;
   logic loadWrite;
   assign loadRead  = kRise && !loadNS && rdS;
   assign loadWrite = kRise && !loadNS && !rdS;

   // Write capture --------------------------------------------------------
   wr_state_type      wrState_r;
   logic [ADDR_W-1:0] wrAddr_r;
   logic              beatValid_r;
   logic [WORD_W-1:0] beatWord_r;
   logic              fifoInReady;
   logic              fifoOutValid;
   logic              fifoOutReady;
   logic [WORD_W-1:0] fifoOutWord;
   logic              captureFirst;
   logic              captureSecond;

   // first beat on the complement edge, second on the next true edge
   assign captureFirst  = kNRise && wrState_r == WR_FIRST;
   assign captureSecond = kRise && wrState_r == WR_SECOND;

   always_ff @(posedge mclk) begin
      if (rst) begin
         wrState_r <= WR_IDLE;
         wrAddr_r  <= '0;
      end else begin
         case (wrState_r)
            WR_IDLE: begin
               if (loadWrite) begin
                  wrState_r <= WR_FIRST;
               end
            end
            WR_FIRST: begin
               if (captureFirst) begin
                  wrState_r <= WR_SECOND;
               end
            end
            WR_SECOND: begin
               if (captureSecond) begin
                  wrState_r <= loadWrite ? WR_FIRST : WR_IDLE;
               end
            end
            default: begin
               wrState_r <= WR_IDLE;
            end
         endcase
         if (loadWrite) begin
            wrAddr_r <= addrS;
         end
      end
   end

   // selects sampled with their own data beat, stored active high
   // Beat is held until the buffer accepts it or until the next captured beat overwrites it
   always_ff @(posedge mclk) begin
      if (rst) begin
         beatValid_r <= 1'h0;
         beatWord_r  <= '0;
      end else if (captureFirst || captureSecond) begin
         beatValid_r <= 1'h1;
         beatWord_r  <= {captureSecond ? BANK_SECOND : BANK_FIRST, wrAddr_r, ~selNS, dataS};
      end else if (fifoInReady) begin
         beatValid_r <= 1'h0;
      end
   end

   // Buffer absorbs beats that arrive while a fetch owns the array
   beat_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_beat_fifo (
      .mclk     (mclk),
      .rst      (rst),
      .inValid  (beatValid_r),
      .inReady  (fifoInReady),
      .inData   (beatWord_r),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData  (fifoOutWord)
   );

   // Read pipeline --------------------------------------------------------
   logic [PIPE_DEPTH-1:0] rdPipe_r;
   logic [ADDR_W-1:0]     rdAddr_r [PIPE_DEPTH];
   logic [PIPE_DEPTH-1:0] rdPipeNxt;
   logic                  fetchEn;
   logic [ADDR_W-1:0]     fetchAddr;
   logic                  launchFirst;
   logic                  launchSecond;
   logic [DATA_W-1:0]     firstWord_r;
   logic [DATA_W-1:0]     secondWord_r;
   int                    lat;

   // DLL off launches half a period earlier
   assign lat       = dllOnS ? LAT_DLL_ON : LAT_DLL_OFF;
   assign rdPipeNxt = {rdPipe_r[PIPE_DEPTH-2:0], loadRead};

   always_ff @(posedge mclk) begin
      if (rst) begin
         rdPipe_r <= '0;
      end else if (halfEdge) begin
         rdPipe_r <= rdPipeNxt;
      end
   end

   for (genvar i = 0; i < PIPE_DEPTH; i++) begin : g_rdaddr
      always_ff @(posedge mclk) begin
         if (rst) begin
            rdAddr_r[i] <= '0;
         end else if (halfEdge) begin
            rdAddr_r[i] <= (i == 0) ? addrS : rdAddr_r[(i == 0) ? 0 : i-1];
         end
      end
   end

   // one fetch reads both arrays, half a period before launch
   assign fetchEn      = halfEdge && rdPipeNxt[lat-1];
   assign fetchAddr    = (lat == 1) ? addrS : rdAddr_r[lat-2];
   assign launchFirst  = halfEdge && rdPipeNxt[lat];
   assign launchSecond = halfEdge && rdPipeNxt[lat+1] && !rdPipeNxt[lat];
   // Fetch owns the single array port; writes wait in the buffer
   assign fifoOutReady = !fetchEn;

   sram_burst_store #(
      .DATA_W (DATA_W),
      .SEL_W  (SEL_W),
      .ADDR_W (ADDR_W)
   ) u_store (
      .mclk         (mclk),
      .writeEn      (fifoOutValid && fifoOutReady),
      .writeBank    (fifoOutWord[WORD_W-1]),
      .writeAddr    (fifoOutWord[WORD_W-2 -: ADDR_W]),
      .writeData    (fifoOutWord[DATA_W-1:0]),
      .laneEn       (fifoOutWord[DATA_W +: SEL_W]),
      .fetchEn      (fetchEn),
      .fetchAddr    (fetchAddr),
      .firstWord_r  (firstWord_r),
      .secondWord_r (secondWord_r)
   );

   // two words launched on successive edges
   // pins released on any edge with nothing to launch
   // Released data is forced to zero, so no stale word lingers
   always_ff @(posedge mclk) begin
      if (rst) begin
         dqOut_r <= '0;
         dqOe_r  <= 1'h0;
      end else if (halfEdge) begin
         dqOe_r  <= launchFirst || launchSecond;
         dqOut_r <= launchFirst ? firstWord_r : (launchSecond ? secondWord_r : '0);
      end
   end

   // valid flag changes on the same edges as the echo clocks
   always_ff @(posedge mclk) begin
      if (rst) begin
         output_valid_flag_r <= 1'h0;
      end else if (halfEdge) begin
         output_valid_flag_r <= launchFirst || launchSecond;
      end
   end

   // echo clocks follow the true clock without gating
   always_ff @(posedge mclk) begin
      if (rst) begin
         echo_timing_out_r <= 1'h0;
         echoTimingOutN_r  <= 1'h1;
      end else begin
         echo_timing_out_r <= kS;
         echoTimingOutN_r  <= !kS;
      end
   end

   // Checks ---------------------------------------------------------------
   logic fetched_r;

   // Set wins: next fetch may share an edge with the last word
   always_ff @(posedge mclk) begin
      if (rst) begin
         fetched_r <= 1'h0;
      end else if (fetchEn) begin
         fetched_r <= 1'h1;
      end else if (launchSecond) begin
         fetched_r <= 1'h0;
      end
   end

   // Pin side
   a_echo_pair: assert property (@(posedge mclk) disable iff (rst)
      echo_timing_out_r != echoTimingOutN_r)
      else $error("echo clocks not complementary");
   a_valid_echo_align: assert property (@(posedge mclk) disable iff (rst)
      $changed(output_valid_flag_r) |-> $changed(echo_timing_out_r) || $changed(kNPrev_r))
      else $error("valid flag moved off an echo edge");
   a_oe_with_valid: assert property (@(posedge mclk) disable iff (rst)
      dqOe_r == output_valid_flag_r)
      else $error("drive and valid disagree");
   a_release_zero: assert property (@(posedge mclk) disable iff (rst)
      !dqOe_r |-> dqOut_r == '0)
      else $error("released pins carry data");

   // Read path
   a_drive_needs_read: assert property (@(posedge mclk) disable iff (rst)
      $rose(dqOe_r) |-> $past(launchFirst) || $past(launchSecond))
      else $error("pins driven without a read");
   a_launch_after_fetch: assert property (@(posedge mclk) disable iff (rst)
      launchFirst |-> fetched_r)
      else $error("word launched before fetch");
   a_second_fetched: assert property (@(posedge mclk) disable iff (rst)
      launchSecond |-> fetched_r)
      else $error("second word without a fetch");
   a_load_true_edge: assert property (@(posedge mclk) disable iff (rst)
      $rose(rdPipe_r[0]) |-> $past(kRise) && !$past(loadNS))
      else $error("read loaded off the true edge");

   // Write path
   a_first_beat_bank: assert property (@(posedge mclk) disable iff (rst)
      captureFirst |=> beatWord_r[WORD_W-1] == BANK_FIRST && beatValid_r)
      else $error("first beat not in first bank");
   a_beat_sel_sampled: assert property (@(posedge mclk) disable iff (rst)
      captureSecond |=> beatWord_r[DATA_W +: SEL_W] == ~$past(selNS))
      else $error("select not taken with its beat");
   a_beat_held: assert property (@(posedge mclk) disable iff (rst)
      beatValid_r && !fifoInReady |=> beatValid_r && $stable(beatWord_r))
      else $error("write beat lost while buffer full");
   a_write_dir: assert property (@(posedge mclk) disable iff (rst)
      loadWrite |=> wrState_r == WR_FIRST && !rdPipe_r[0])
      else $error("write load took read path");
   a_fetch_excludes_write: assert property (@(posedge mclk) disable iff (rst)
      fetchEn && fifoOutValid |=> fifoOutValid)
      else $error("write dropped during fetch");

   c_read_burst:  cover property (@(posedge mclk) disable iff (rst) launchSecond);
   c_write_burst: cover property (@(posedge mclk) disable iff (rst) captureSecond);
   c_masked_write: cover property (@(posedge mclk) disable iff (rst)
      captureFirst && selNS != '0);
   c_dll_off_read: cover property (@(posedge mclk) disable iff (rst)
      launchFirst && !dllOnS);
   // Back-to-back reads: next fetch on the last word's edge
   c_back_to_back: cover property (@(posedge mclk) disable iff (rst) launchSecond && fetchEn);
endmodule

// ===== tb/sram_ctrl_model.sv
// Purpose: Memory controller model driving the SRAM pins
// Assumes: K clock free running at 200 ns, unrelated in phase to mclk
// Notes:   Pins change two mclk cycles after each K edge
`timescale 1ns/1ps
module sram_ctrl_model #(
   parameter int DW = 36,
   parameter int AW = 4,
   parameter int SW = 4
) (
   input  wire logic          mclk,
   output      logic          kClk,
   output      logic          kClkN,
   output      logic          load_strobe_n,
   output      logic          readNotWrite,
   output      logic [AW-1:0] addr,
   output      logic [SW-1:0] writeSelN,
   output wire logic [DW-1:0] dqIn,
   input  wire logic [DW-1:0] dqOut_r,
   input  wire logic          dqOe_r,
   input  wire logic          output_valid_flag_r,
   input  wire logic          echo_timing_out_r
);
   logic [DW-1:0] drvDq = '0;
   logic [DW-1:0] lastDq = '0;
   logic          drvOe = 1'b0;
   logic [DW-1:0] rdQ[$];
   initial begin
      kClk = 1'b0;
      load_strobe_n = 1'b1;
      readNotWrite = 1'b0;
      addr = '0;
      writeSelN = '1;
      #7;
      forever #100 kClk = ~kClk;
   end
   assign kClkN = ~kClk;
   assign dqIn = (dqOe_r === 1'b1) ? dqOut_r : (drvOe ? drvDq : ~lastDq);
   always @(posedge mclk) lastDq <= dqIn;
   task automatic q1;
      @(posedge kClk);
      repeat (2) @(posedge mclk);
   endtask
   task automatic q3;
      @(negedge kClk);
      repeat (2) @(posedge mclk);
   endtask
   task automatic cmd(input logic rd, input logic [AW-1:0] a);
      load_strobe_n <= 1'b0;
      readNotWrite <= rd;
      addr <= a;
   endtask
   task automatic rd(input logic [AW-1:0] a);
      q3;
      cmd(1'b1, a);
      q1;
      load_strobe_n <= 1'b1;
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d0, input logic [DW-1:0] d1,
                     input logic [SW-1:0] s0, input logic [SW-1:0] s1, input logic rdNext);
      q3;
      cmd(1'b0, a);
      q1;
      load_strobe_n <= 1'b1;
      drvOe <= 1'b1;
      drvDq <= d0;
      writeSelN <= s0;
      q3;
      drvDq <= d1;
      writeSelN <= s1;
      if (rdNext)
         cmd(1'b1, a);
      q1;
      load_strobe_n <= 1'b1;
      // off the bus before read data
      drvOe <= 1'b0;
      writeSelN <= '1;
   endtask
   // load low only around complementary edge
   task automatic stray;
      q1;
      load_strobe_n <= 1'b0;
      readNotWrite <= 1'b1;
      q3;
      load_strobe_n <= 1'b1;
   endtask
   initial forever begin
      @(echo_timing_out_r);
      repeat (2) @(posedge mclk);
      if (output_valid_flag_r === 1'b1)
         rdQ.push_back(dqOut_r);
   end
endmodule

// ===== tb/ddr_burst2_sram_bus_interface_tb.sv
// Purpose: Self-checking bench for the burst-of-two SRAM bus interface
// Assumes: 36-bit bus, K period 200 ns, mclk 25 ns
// Notes:   Expected words come from a shadow of both arrays
`timescale 1ns/1ps
module ddr_burst2_sram_bus_interface_tb;
   import sram_if_pkg::*;
   localparam int DW = WIDTH_X36;
   localparam int AW = 4;
   localparam int SW = SELS_X36;
   localparam int LW = DW / SW;
   logic          mclk = 1'b0;
   logic          rst = 1'b1;
   logic          dllOffN = 1'b1;
   logic          kClk, kClkN, load_strobe_n, readNotWrite;
   logic [AW-1:0] addr;
   logic [SW-1:0] writeSelN;
   wire  [DW-1:0] dqIn;
   logic [DW-1:0] dqOut_r;
   logic          dqOe_r, output_valid_flag_r, echo_timing_out_r, echoTimingOutN_r;
   logic [DW-1:0] mem0 [2**AW];
   logic [DW-1:0] mem1 [2**AW];
   logic [DW-1:0] expQ[$];
   int            bad_count = 0;
   int            checked = 0;
   int            oeCnt = 0;
   int            latOn, latOff;

   always #12.5 mclk = ~mclk;
   always @(posedge mclk) if (dqOe_r === 1'b1) oeCnt++;

   ddr_burst2_sram_bus_interface #(.DATA_W(DW), .ADDR_W(AW)) i_dut (
      .mclk(mclk), .rst(rst), .kClk(kClk), .kClkN(kClkN), .load_strobe_n(load_strobe_n),
      .readNotWrite(readNotWrite), .addr(addr), .writeSelN(writeSelN),
      .dll_disable_n(dllOffN), .dqIn(dqIn), .dqOut_r(dqOut_r), .dqOe_r(dqOe_r),
      .output_valid_flag_r(output_valid_flag_r), .echo_timing_out_r(echo_timing_out_r),
      .echoTimingOutN_r(echoTimingOutN_r));
   sram_ctrl_model #(.DW(DW), .AW(AW), .SW(SW)) i_ctrl (
      .mclk(mclk), .kClk(kClk), .kClkN(kClkN), .load_strobe_n(load_strobe_n),
      .readNotWrite(readNotWrite), .addr(addr), .writeSelN(writeSelN), .dqIn(dqIn),
      .dqOut_r(dqOut_r), .dqOe_r(dqOe_r), .output_valid_flag_r(output_valid_flag_r),
      .echo_timing_out_r(echo_timing_out_r));

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] nw,
                                           input logic [SW-1:0] selN);
      merge = old;
      for (int i = 0; i < SW; i++)
         if (!selN[i])
            merge[i*LW +: LW] = nw[i*LW +: LW];
   endfunction
   task automatic wrX(input int a, input logic [DW-1:0] d0, input logic [DW-1:0] d1,
                      input logic [SW-1:0] s0, input logic [SW-1:0] s1, input logic rdNext);
      mem0[a] = merge(mem0[a], d0, s0);
      mem1[a] = merge(mem1[a], d1, s1);
      if (rdNext) begin
         expQ.push_back(mem0[a]);
         expQ.push_back(mem1[a]);
      end
      i_ctrl.wr(a[AW-1:0], d0, d1, s0, s1, rdNext);
   endtask
   task automatic rdX(input int a);
      expQ.push_back(mem0[a]);
      expQ.push_back(mem1[a]);
      i_ctrl.rd(a[AW-1:0]);
   endtask
   // Wait for all words, then for the bus to be released
   task automatic drain(input int oeExp);
      int k;
      k = 0;
      while ((i_ctrl.rdQ.size() < expQ.size() || dqOe_r !== 1'b0) && k < 200) begin
         @(posedge mclk);
         k++;
      end
      check("drain in time", k < 200, 1);
      check("released data", dqOut_r, 0);
      check("words returned", i_ctrl.rdQ.size(), expQ.size());
      while (expQ.size() > 0 && i_ctrl.rdQ.size() > 0)
         check("read word", i_ctrl.rdQ.pop_front(), expQ.pop_front());
      check("drive cycles", oeCnt, oeExp);
      expQ.delete();
      i_ctrl.rdQ.delete();
      oeCnt = 0;
   endtask
   task automatic t_echo;
      int   tg;
      logic prev;
      tg = 0;
      @(posedge kClk);
      prev = echo_timing_out_r;
      repeat (32) begin
         @(posedge mclk);
         if (echo_timing_out_r !== prev)
            tg++;
         prev = echo_timing_out_r;
         check("echo pair", echoTimingOutN_r ^ echo_timing_out_r, 1);
      end
      check("echo toggles", tg, 8);
   endtask
   task automatic t_lat(input logic off, output int n);
      dllOffN <= ~off;
      oeCnt = 0;
      fork
         rdX(3);
         begin
            @(negedge load_strobe_n);
            n = 0;
            while (output_valid_flag_r !== 1'b1 && n < 100) begin
               @(posedge mclk);
               n++;
            end
         end
      join
      drain(8);
   endtask

   initial begin
      #100000;
      bad_count++;
      test_done;
   end
   initial begin
      @(posedge mclk);
      #1;
      check("oe in reset", dqOe_r, 0);
      check("valid in reset", output_valid_flag_r, 0);
      check("echo low in reset", echoTimingOutN_r, 1);
      check("echo in reset", echo_timing_out_r, 0);
      @(posedge mclk);
      rst <= 1'b0;
      repeat (8) @(posedge mclk);
      t_echo;
      oeCnt = 0;
      wrX(3, 36'h1_2345_6789, 36'hF_EDCB_A987, '0, '0, 1'b0);
      rdX(3);
      drain(8);
      // Partial lanes keep old bytes
      wrX(3, 36'hA_AAAA_AAAA, 36'h5_5555_5555, 4'h5, 4'hA, 1'b0);
      rdX(3);
      drain(8);
      // Write, read, read on consecutive true edges
      wrX(5, 36'h0_0F0F_1E1E, 36'hC_3C3C_4B4B, '0, '0, 1'b1);
      rdX(3);
      drain(16);
      // Load seen only at the complementary edge
      i_ctrl.stray;
      repeat (60) @(posedge mclk);
      check("stray load words", i_ctrl.rdQ.size(), 0);
      drain(0);
      t_lat(1'b0, latOn);
      t_lat(1'b1, latOff);
      check("latency step", latOn - latOff, 4);
      test_done;
   end
endmodule
